// [rtl/adi_cfg.svh]
// Constants of the interrupt vector and reset status block.
// Assumes a 200 MHz die base clock and a 16-bit global register address.
`ifndef ADI_CFG_SVH
`define ADI_CFG_SVH
`define ADI_BASE_BLK   8'h02
`define ADI_BASE_NBLK  8'h03
`define ADI_OFS_SRC_MIRROR 8'h00
`define ADI_OFS_VECTOR     8'h02
`define ADI_OFS_VOLT_STAT  8'h04
`define ADI_OFS_BUS_XCVR   8'h06
`define ADI_OFS_HS_STAT    8'h08
`define ADI_OFS_LS_STAT    8'h0a
`define ADI_OFS_HALL       8'h0c
`define ADI_OFS_RST_CAUSE  8'h15
`define ADI_NSRC       18
`define ADI_VEC_STEP   2
`define ADI_VEC_NONE   6'h00
`define ADI_RC_POR     0
`define ADI_RC_CORE_LV 1
`define ADI_RC_IO_LV   2
`define ADI_RC_WAKE    3
`define ADI_RC_EXT     4
`define ADI_RC_WDOG    5
`define ADI_RC_RST     6'h01
`define ADI_CLK_MHZ    200
`define ADI_HOLD_NS    1000
`define ADI_DGL_NS     500
`endif

// [rtl/adi_pkg.sv]
// Types of the interrupt vector and reset status block.
// Assumes nothing beyond the constants header.
`default_nettype none
package adi_pkg;
    typedef enum logic [1:0] {
        ADI_RP_IDLE,
        ADI_RP_DRIVE,
        ADI_RP_HOLD
    } adi_rpin_t;
endpackage : adi_pkg
`default_nettype wire

// [rtl/adi_irq_rst.sv]
// Interrupt priority vector, source mirror, reset pin and reset status.
// Assumes sources and register reads come from logic on clk_sys_i.
`include "adi_cfg.svh"
`default_nettype none
module adi_irq_rst
    import adi_pkg::*;
#(
    parameter int HOLD_CYC = (`ADI_HOLD_NS * `ADI_CLK_MHZ) / 1000,
    parameter int DGL_CYC  = (`ADI_DGL_NS * `ADI_CLK_MHZ + 999) / 1000
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        rd_en_i,
    input  wire logic        wr_en_i,
    input  wire logic [15:0] addr_i,
    output logic      [15:0] rd_data_o,
    input  wire logic        low_voltage_irq_i,
    input  wire logic        regulator_hot_irq_i,
    input  wire logic        low_battery_irq_i,
    input  wire logic [3:0]  timer_chan_irq_i,
    input  wire logic        timer_overflow_irq_i,
    input  wire logic        serial_err_irq_i,
    input  wire logic        serial_tx_irq_i,
    input  wire logic        serial_rx_irq_i,
    input  wire logic        conversion_sequence_done_irq_i,
    input  wire logic        bus_driver_overtemp_irq_i,
    input  wire logic        high_side_overtemp_irq_i,
    input  wire logic        low_side_overtemp_irq_i,
    input  wire logic        hall_supply_overtemp_irq_i,
    input  wire logic        high_voltage_irq_i,
    input  wire logic        regulator_overvoltage_irq_i,
    input  wire logic        normal_mode_i,
    input  wire logic        sleep_mode_i,
    input  wire logic        stop_wake_i,
    input  wire logic        wake_event_i,
    input  wire logic        por_cond_i,
    input  wire logic        core_low_voltage_i,
    input  wire logic        io_low_voltage_i,
    input  wire logic        watchdog_fault_i,
    input  wire logic        reset_pin_i,
    output logic             reset_pin_o,
    output logic             reset_pin_oe_o,
    output logic             reset_mode_o,
    output logic             host_irq_output_o
);

    ////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic adi_hit(input logic [15:0] a,
                                     input logic [7:0] ofs);
        adi_hit = ((a[15:8] == `ADI_BASE_BLK)
                || (a[15:8] == `ADI_BASE_NBLK))
                && (a[7:0] == ofs);
    endfunction : adi_hit

    function automatic logic [5:0] adi_vec(input logic [17:0] p);
        logic [5:0] v;
        v = `ADI_VEC_NONE;
        for (int i = `ADI_NSRC - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                v = 6'((i + 1) * `ADI_VEC_STEP);
            end
        end
        adi_vec = v;
    endfunction : adi_vec

    ////////////////////////////////////////////////////////////////////
    // Reset release.

    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////
    // Reset pin sampling and hold state machine.

    logic [1:0]  pin_sync_r;
    adi_rpin_t   rp_r;
    logic [15:0] hold_cnt_r;
    logic [15:0] dgl_cnt_r;
    logic        ext_evt;
    logic        ext_act_r;
    logic        wake_rst_evt;
    logic        int_rst;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            pin_sync_r <= 2'b11;
        else
            pin_sync_r <= {pin_sync_r[0], reset_pin_i};
    end

    assign wake_rst_evt = sleep_mode_i & wake_event_i;
    assign int_rst = por_cond_i | core_low_voltage_i
                   | io_low_voltage_i | watchdog_fault_i | wake_rst_evt;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            rp_r <= ADI_RP_DRIVE;
        else
        begin
            case (rp_r)
                ADI_RP_IDLE:
                    if (int_rst)
                        rp_r <= ADI_RP_DRIVE;
                ADI_RP_DRIVE:
                    if (!int_rst)
                        rp_r <= ADI_RP_HOLD;
                ADI_RP_HOLD:
                    if (int_rst)
                        rp_r <= ADI_RP_DRIVE;
                    else if (hold_cnt_r == 16'(HOLD_CYC - 1))
                        rp_r <= ADI_RP_IDLE;
                default:
                    rp_r <= ADI_RP_DRIVE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            hold_cnt_r <= 16'h0000;
        else if (rp_r == ADI_RP_HOLD)
            hold_cnt_r <= hold_cnt_r + 16'h0001;
        else
            hold_cnt_r <= 16'h0000;
    end

    // Counting restarts while the pin is driven here, so the sync delay
    // after release cannot look like an external reset.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            dgl_cnt_r <= 16'h0000;
        else if (pin_sync_r[1] || rp_r != ADI_RP_IDLE)
            dgl_cnt_r <= 16'h0000;
        else if (dgl_cnt_r != 16'(DGL_CYC))
            dgl_cnt_r <= dgl_cnt_r + 16'h0001;
    end
    assign ext_evt = (dgl_cnt_r == 16'(DGL_CYC - 1));

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            ext_act_r <= 1'b0;
        else if (ext_evt)
            ext_act_r <= 1'b1;
        else if (pin_sync_r[1])
            ext_act_r <= 1'b0;
    end

    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_o = (rp_r != ADI_RP_IDLE);
    assign reset_mode_o   = reset_pin_oe_o | ext_act_r;

    ////////////////////////////////////////////////////////////////////
    // Interrupt sources.

    logic [17:0] cond;
    logic [17:0] ack;
    logic [17:0] prev_r;
    logic [17:0] pend_r;
    logic        rd_go;
    logic        volt_rd;
    logic        vec_rd;
    logic        combined_voltage_irq;

    assign cond = {regulator_overvoltage_irq_i, high_voltage_irq_i,
                   hall_supply_overtemp_irq_i, low_side_overtemp_irq_i,
                   high_side_overtemp_irq_i, bus_driver_overtemp_irq_i,
                   conversion_sequence_done_irq_i, serial_rx_irq_i,
                   serial_tx_irq_i, serial_err_irq_i,
                   timer_overflow_irq_i, timer_chan_irq_i,
                   low_battery_irq_i, regulator_hot_irq_i,
                   low_voltage_irq_i};

    assign rd_go   = rd_en_i & ~wr_en_i;
    assign volt_rd = rd_go & adi_hit(addr_i, `ADI_OFS_VOLT_STAT);
    assign ack[2:0]   = {3{volt_rd}};
    assign ack[11:3]  = 9'h000;
    assign ack[12] = rd_go & adi_hit(addr_i, `ADI_OFS_BUS_XCVR);
    assign ack[13] = rd_go & adi_hit(addr_i, `ADI_OFS_HS_STAT);
    assign ack[14] = rd_go & adi_hit(addr_i, `ADI_OFS_LS_STAT);
    assign ack[15] = rd_go & adi_hit(addr_i, `ADI_OFS_HALL);
    assign ack[17:16] = {2{volt_rd}};

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= 18'h00000;
        else if (reset_mode_o)
            prev_r <= 18'h00000;
        else
            prev_r <= cond;
    end

    genvar g;
    generate
        for (g = 0; g < `ADI_NSRC; g++)
        begin : g_src
            always_ff @(posedge clk_sys_i or negedge rst_n)
            begin
                if (!rst_n)
                    pend_r[g] <= 1'b0;
                else if (reset_mode_o)
                    pend_r[g] <= 1'b0;
                else if (g >= 3 && g <= 11)
                    pend_r[g] <= cond[g];
                else
                    pend_r[g] <= (cond[g] & ~prev_r[g])
                               | (pend_r[g] & ~ack[g]);
            end
        end
    endgenerate

    assign combined_voltage_irq = pend_r[0] | pend_r[1] | pend_r[2]
                                | pend_r[16] | pend_r[17];

    ////////////////////////////////////////////////////////////////////
    // Vector and host interrupt.

    logic [5:0] vec_r;
    logic       irq_r;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            vec_r <= `ADI_VEC_NONE;
        else if (reset_mode_o || stop_wake_i)
            vec_r <= `ADI_VEC_NONE;
        else
            vec_r <= adi_vec(pend_r);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            irq_r <= 1'b0;
        else
            irq_r <= normal_mode_i & (|pend_r) & ~reset_mode_o;
    end
    assign host_irq_output_o = irq_r;

    ////////////////////////////////////////////////////////////////////
    // Reset status flags and register reads.

    logic [5:0]  rc_flags_r;
    logic [5:0]  rc_set;
    logic [5:0]  rc_view;
    logic        rc_rd;
    logic [15:0] rd_r;

    assign rc_rd  = rd_go & adi_hit(addr_i, `ADI_OFS_RST_CAUSE);
    assign vec_rd = rd_go & adi_hit(addr_i, `ADI_OFS_VECTOR);

    always_comb
    begin
        rc_set = 6'h00;
        rc_set[`ADI_RC_POR]     = por_cond_i;
        rc_set[`ADI_RC_CORE_LV] = core_low_voltage_i;
        rc_set[`ADI_RC_IO_LV]   = io_low_voltage_i;
        rc_set[`ADI_RC_WAKE]    = wake_rst_evt;
        rc_set[`ADI_RC_EXT]     = ext_evt;
        rc_set[`ADI_RC_WDOG]    = watchdog_fault_i;
    end

    // Reset mode does not touch these flags; set wins over read clear.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            rc_flags_r <= `ADI_RC_RST;
        else if (rc_rd)
            rc_flags_r <= rc_set;
        else
            rc_flags_r <= rc_flags_r | rc_set;
    end

    always_comb
    begin
        rc_view = rc_flags_r;
        if (rc_flags_r[`ADI_RC_POR] || rc_flags_r[`ADI_RC_WAKE])
        begin
            rc_view[`ADI_RC_CORE_LV] = 1'b0;
            rc_view[`ADI_RC_IO_LV]   = 1'b0;
        end
    end

    // Writes never reach a register of this block.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            rd_r <= 16'h0000;
        else if (rd_go)
        begin
            if (adi_hit(addr_i, `ADI_OFS_SRC_MIRROR))
                rd_r <= {2'b00, pend_r[15:3], combined_voltage_irq};
            else if (vec_rd)
                rd_r <= {10'h000, vec_r};
            else if (rc_rd)
                rd_r <= {10'h000, rc_view};
            else
                rd_r <= 16'h0000;
        end
    end
    assign rd_data_o = rd_r;

    ////////////////////////////////////////////////////////////////////
    // Checks.

    a_vec_even: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        vec_r[0] == 1'b0) else $error("odd vector");
    a_vec_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !reset_mode_o && pend_r == 18'h0 && !stop_wake_i |=> vec_r == 6'h00)
        else $error("idle vector not zero");
    a_vec_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        stop_wake_i |=> vec_r == 6'h00) else $error("wake vector");
    a_vec_lowv: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        pend_r[0] && !reset_mode_o && !stop_wake_i |=> vec_r == 6'h02)
        else $error("low voltage code");
    a_vec_last: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        pend_r == 18'h20000 && !reset_mode_o && !stop_wake_i
        |=> vec_r == 6'h24) else $error("overvoltage code");
    a_vec_tmr: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        pend_r[7:0] == 8'h08 && !reset_mode_o && !stop_wake_i
        |=> vec_r == 6'h08) else $error("timer code");
    a_flags_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        rc_rd && rc_set == 6'h00 |=> rc_flags_r == 6'h00)
        else $error("status not cleared");
    a_flags_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        rc_rd && rc_flags_r[0] |=> rd_data_o[2:1] == 2'b00)
        else $error("low voltage not masked");
    a_pin_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $fell(int_rst) && rp_r == ADI_RP_DRIVE |=> reset_pin_oe_o [*4])
        else $error("pin released early");
    a_irq_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !normal_mode_i |=> !host_irq_output_o)
        else $error("irq outside normal");
    a_edge_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        volt_rd && low_voltage_irq_i && prev_r[0] && !reset_mode_o
        |=> !pend_r[0]) else $error("rearmed without edge");

    c_ext_rst: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        ext_evt);
    c_ack_volt: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        volt_rd && pend_r[0]);
    c_irq_up: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        $rose(host_irq_output_o));
    c_sleep_wake: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        wake_rst_evt);

endmodule : adi_irq_rst
`default_nettype wire

// [tb/adi_host_model.sv]
// Host model that reads and writes registers of the analog die.
// Assumes requests are taken on the rising edge and answered one edge later.
`include "adi_cfg.svh"
`default_nettype none
module adi_host_model
(
    input  wire logic        clk_i,
    output logic             rd_en_o,
    output logic             wr_en_o,
    output logic      [15:0] addr_o,
    input  wire logic [15:0] rd_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////
    initial
    begin
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        addr_o  = 16'hffff;
    end
    ////////////////////////////////////////////////////////////
    task automatic rd(input logic nb, input logic [7:0] ofs, output logic [15:0] d);
        @(negedge clk_i);
        rd_en_o = 1'b1;
        addr_o  = {nb ? `ADI_BASE_NBLK : `ADI_BASE_BLK, ofs};
        @(negedge clk_i);
        rd_en_o = 1'b0;
        addr_o  = ~addr_o;
        @(negedge clk_i);
        d = rd_data_i;
    endtask : rd
    task automatic wr(input logic [7:0] ofs);
        @(negedge clk_i);
        wr_en_o = 1'b1;
        addr_o  = {`ADI_BASE_BLK, ofs};
        @(negedge clk_i);
        wr_en_o = 1'b0;
        addr_o  = ~addr_o;
    endtask : wr
endmodule : adi_host_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the interrupt vector and reset status block.
// Assumes the host model and the design files are compiled first.
`include "adi_cfg.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 4;
    localparam int DGL  = 4;
    localparam logic [4:0]  CT [5] = '{5'b11000, 5'b01000, 5'b00100, 5'b00011, 5'b01011};
    localparam logic [15:0] CE [5] = '{16'h01, 16'h02, 16'h04, 16'h08, 16'h08};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rd_en, wr_en, pin_o, pin_oe, rst_mode, irq, pin;
    logic [15:0] addr, rdat, d;
    logic [17:0] src = '0;
    logic        stw = 1'b0, nrm = 1'b1, wd = 1'b0, ext = 1'b0;
    logic [4:0]  cnd = '0;
    int          n_fail = 0, tests_run = 0, cyc = 0;
    always #2.5 clk = ~clk;
    assign pin = (pin_oe ? pin_o : 1'b1) & ~ext;
    ////////////////////////////////////////////////////////////
    adi_irq_rst #(.HOLD_CYC(HOLD), .DGL_CYC(DGL)) i_dut (
        .clk_sys_i(clk), .rst_n_i(rst_n), .rd_en_i(rd_en), .wr_en_i(wr_en),
        .addr_i(addr), .rd_data_o(rdat), .low_voltage_irq_i(src[0]),
        .regulator_hot_irq_i(src[1]), .low_battery_irq_i(src[2]),
        .timer_chan_irq_i(src[6:3]), .timer_overflow_irq_i(src[7]),
        .serial_err_irq_i(src[8]), .serial_tx_irq_i(src[9]), .serial_rx_irq_i(src[10]),
        .conversion_sequence_done_irq_i(src[11]), .bus_driver_overtemp_irq_i(src[12]),
        .high_side_overtemp_irq_i(src[13]), .low_side_overtemp_irq_i(src[14]),
        .hall_supply_overtemp_irq_i(src[15]), .high_voltage_irq_i(src[16]),
        .regulator_overvoltage_irq_i(src[17]), .normal_mode_i(nrm),
        .sleep_mode_i(cnd[1]), .stop_wake_i(stw), .wake_event_i(cnd[0]),
        .por_cond_i(cnd[4]), .core_low_voltage_i(cnd[3]), .io_low_voltage_i(cnd[2]),
        .watchdog_fault_i(wd), .reset_pin_i(pin), .reset_pin_o(pin_o),
        .reset_pin_oe_o(pin_oe), .reset_mode_o(rst_mode), .host_irq_output_o(irq));
    adi_host_model i_host (.clk_i(clk), .rd_en_o(rd_en), .wr_en_o(wr_en),
        .addr_o(addr), .rd_data_i(rdat));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle
    task automatic wait_done;
        int n;
        n = 0;
        while ((pin_oe !== 1'b0 || rst_mode !== 1'b0) && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("reset_done", 16'h0000, 16'(n / 200));
    endtask : wait_done
    task automatic rd_vector(input logic [15:0] e);
        i_host.rd(1'b0, `ADI_OFS_VECTOR, d);
        chk("vector", e, d);
    endtask : rd_vector
    function automatic logic [7:0] ack_ofs(input int i);
        if (i < 3 || i > 15)
            return `ADI_OFS_VOLT_STAT;
        if (i >= 12)
            return `ADI_OFS_BUS_XCVR + 8'(2 * (i - 12));
        return 8'h00;
    endfunction : ack_ofs
    ////////////////////////////////////////////////////////////
    task automatic t_cause;
        i_host.wr(`ADI_OFS_RST_CAUSE);
        i_host.rd(1'b0, `ADI_OFS_RST_CAUSE, d);
        chk("cause_power_on", 16'h0001, d);
        i_host.rd(1'b1, `ADI_OFS_RST_CAUSE, d);
        chk("cause_cleared", 16'h0000, d);
        i_host.rd(1'b0, 8'h40, d);
        chk("unmapped", 16'h0000, d);
        rd_vector(16'h0000);
    endtask : t_cause
    task automatic t_prio;
        for (int i = 0; i < 18; i++)
        begin
            src = 18'h1 << i;
            settle(3);
            rd_vector(16'(2 * (i + 1)));
            chk("host_irq", 16'h0001, {15'h0, irq});
            i_host.rd(1'b0, `ADI_OFS_SRC_MIRROR, d);
            chk("mirror", 16'h1 << ((i < 3 || i > 15) ? 0 : i - 2), d);
            src = '0;
            settle(3);
            if (ack_ofs(i) != 8'h00)
            begin
                rd_vector(16'(2 * (i + 1)));
                i_host.rd(1'b0, ack_ofs(i), d);
            end
            rd_vector(16'h0000);
            chk("host_irq_off", 16'h0000, {15'h0, irq});
        end
    endtask : t_prio
    task automatic t_all;
        src = '1;
        settle(3);
        rd_vector(16'h0002);
        i_host.rd(1'b0, `ADI_OFS_SRC_MIRROR, d);
        chk("mirror_all", 16'h3fff, d);
        stw = 1'b1;
        settle(3);
        rd_vector(16'h0000);
        stw = 1'b0;
        src = '0;
        for (int k = 0; k < 5; k++)
            i_host.rd(1'b0, `ADI_OFS_VOLT_STAT + 8'(2 * k), d);
        rd_vector(16'h0000);
    endtask : t_all
    task automatic t_edge;
        src[0] = 1'b1;
        settle(3);
        i_host.rd(1'b0, `ADI_OFS_VOLT_STAT, d);
        rd_vector(16'h0000);
        src[0] = 1'b0;
        settle(3);
        src[0] = 1'b1;
        settle(3);
        rd_vector(16'h0002);
        src[0] = 1'b0;
        i_host.rd(1'b0, `ADI_OFS_VOLT_STAT, d);
        nrm = 1'b0;
        src[3] = 1'b1;
        settle(3);
        chk("irq_not_normal", 16'h0000, {15'h0, irq});
        nrm = 1'b1;
        settle(3);
        chk("irq_normal", 16'h0001, {15'h0, irq});
        src[3] = 1'b0;
    endtask : t_edge
    task automatic t_rst_pin;
        int n;
        src[2] = 1'b1;
        settle(3);
        src[2] = 1'b0;
        wd = 1'b1;
        settle(2);
        chk("pin_driven", 16'h0001, {15'h0, pin_oe});
        chk("pin_level", 16'h0000, {15'h0, pin});
        settle(3);
        wd = 1'b0;
        n = 0;
        while (pin_oe === 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        chk("hold_len", 16'h0001, {15'h0, n >= HOLD && n <= HOLD + 3});
        wait_done();
        rd_vector(16'h0000);
        i_host.rd(1'b0, `ADI_OFS_RST_CAUSE, d);
        chk("cause_watchdog", 16'h0020, d);
    endtask : t_rst_pin
    task automatic t_flags;
        for (int k = 0; k < 5; k++)
        begin
            cnd = CT[k];
            settle(3);
            cnd = '0;
            wait_done();
            i_host.rd(1'b0, `ADI_OFS_RST_CAUSE, d);
            chk("cause_flags", CE[k], d);
        end
    endtask : t_flags
    task automatic t_ext;
        ext = 1'b1;
        settle(DGL + 4);
        chk("ext_mode", 16'h0001, {15'h0, rst_mode});
        ext = 1'b0;
        wait_done();
        i_host.rd(1'b0, `ADI_OFS_RST_CAUSE, d);
        chk("cause_external", 16'h0010, d);
        ext = 1'b1;
        settle(2);
        ext = 1'b0;
        settle(DGL + 4);
        chk("glitch_mode", 16'h0000, {15'h0, rst_mode});
        i_host.rd(1'b0, `ADI_OFS_RST_CAUSE, d);
        chk("cause_glitch", 16'h0000, d);
    endtask : t_ext
    ////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        wait_done();
        t_cause();
        t_prio();
        t_all();
        t_edge();
        t_rst_pin();
        t_flags();
        t_ext();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
